// ### rtl/hbp_pkg.sv
// Constants for the host bus port with one-second timing.
// Notes on behaviour
// - Device reset low puts the port into its reset state.
// - Pin as output carries the reference divided by 8000.
// - Strobe mode, write line high: store data at the 11-bit address.
// - Strobe mode, write line low: drive the addressed register out.
// - Strobe mode access needs select low, strobe low, reset high.
// - Async mode: read strobe low drives the addressed register.
// - Async mode: falling write strobe stores data at the address.
// - Async write needs select low, read strobe high, reset high.
// - Select high: data bus floats, interrupt output stays high (inactive).
// - Every access decodes an 11-bit register address.
// - Timing strap high picks strobe mode, low picks async mode.
// - Data bus is two-way: write data in, read data out.
`default_nettype none
package hbp_pkg;
   // ****************************************************
   // Register map
   // ****************************************************
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam logic [10:0] OFS_MODE   = 11'h200;
   localparam logic [10:0] OFS_STATUS = 11'h201;
   localparam logic [10:0] OFS_LATCH  = 11'h202;
   localparam logic [7:0]  MODE_RST   = 8'h00;
   localparam int          MODE_SEC_OUT_BIT = 0;
   localparam logic [7:0]  UNMAPPED_VAL = 8'h00;
   // ****************************************************
   // Timing
   // ****************************************************
   localparam int REF_HZ  = 8000;
   localparam int SEC_DIV = 8000;
   localparam int DIV_W   = 13;
   localparam int SYNC_N  = 3;
endpackage
`default_nettype wire

// ### rtl/hbp_top.sv
// Host bus port: register access in two bus modes and one-second pin.
`default_nettype none
module hbp_top
#(
   parameter int SEC_DIV = hbp_pkg::SEC_DIV
)
(
   input  wire logic        REF_CLK,
   input  wire logic        SYS_RST,
   input  wire logic        HOST_RESET_N,
   input  wire logic        HOST_BUS_CLK,
   input  wire logic        BUS_TIMING_SELECT,
   input  wire logic        HOST_SELECT_N,
   input  wire logic        CTRL_WNR_RD_N,
   input  wire logic        CTRL_AS_N_WR_N,
   input  wire logic [10:0] HOST_ADDR,
   input  wire logic [7:0]  HOST_DATA_I,
   output logic      [7:0]  HOST_DATA_O,
   output logic             HOST_DATA_OE,
   output logic             HOST_IRQ_N,
   input  wire logic        FRAME_RATE_REF_IN,
   input  wire logic        SECOND_PULSE_PIN_I,
   output logic             SECOND_PULSE_PIN_O,
   output logic             SECOND_PULSE_PIN_OE
);

   // ****************************************************
   // State
   // ****************************************************
   typedef struct packed {
      logic [2:0]       rst_n;
      logic [2:0]       bclk;
      logic [2:0]       refc;
      logic [2:0]       sec;
      logic [2:0]       a2;
      logic [2:0]       a1;
      logic [1:0]       cs_n;
      logic [1:0]       tsel;
      logic [1:0][10:0] addr;
      logic [1:0][7:0]  din;
      logic [7:0]       mode;
      logic [12:0]      div;
      logic             sec_o;
      logic [7:0]       ref_cnt;
      logic [7:0]       latch;
      logic [7:0]       rdata;
      logic             oe;
   } hbp_state_t;

   localparam logic [12:0] DIV_LAST =
      13'(SEC_DIV - 1);
   localparam logic [12:0] DIV_HALF =
      13'(SEC_DIV / 2 - 1);

   hbp_state_t s_q;
   hbp_state_t s_d;

   // Decoded views of the synchronised pins.
   logic       dev_rst;
   logic       cs_on;
   logic       strobe_mode;
   logic       bclk_rise;
   logic       ref_rise;
   logic       sec_rise;
   logic       wr_fall;
   logic       sync_qual;
   logic       sync_wr;
   logic       sync_rd;
   logic       async_rd;
   logic       async_wr;
   logic       do_wr;
   logic       sec_out;
   logic [7:0] rd_mux;

   // Stage 1 of every synchroniser feeds only stage 2; edges use 2 and 3.
   always_comb
   begin
      dev_rst     = !s_q.rst_n[1];
      cs_on       = !s_q.cs_n[1];
      strobe_mode = s_q.tsel[1];
      bclk_rise   = s_q.bclk[1] && !s_q.bclk[2];
      ref_rise    = s_q.refc[1] && !s_q.refc[2];
      sec_rise    = s_q.sec[1] && !s_q.sec[2];
      wr_fall     = !s_q.a1[1] && s_q.a1[2];
      sync_qual   = strobe_mode && cs_on && !s_q.a1[1]
                    && !dev_rst;
      sync_wr     = sync_qual && bclk_rise && s_q.a2[1];
      sync_rd     = sync_qual && !s_q.a2[1];
      async_rd    = !strobe_mode && cs_on && !s_q.a2[1]
                    && !dev_rst;
      async_wr    = !strobe_mode && cs_on && s_q.a2[1]
                    && wr_fall && !dev_rst;
      do_wr       = (sync_wr || async_wr)
                    && s_q.addr[1] == hbp_pkg::OFS_MODE;
      sec_out     = s_q.mode[hbp_pkg::MODE_SEC_OUT_BIT];
   end

   // Read decode; unmapped offsets read as zero.
   always_comb
   begin
      case (s_q.addr[1])
         hbp_pkg::OFS_MODE:   rd_mux = s_q.mode;
         hbp_pkg::OFS_STATUS: rd_mux = {5'h00, strobe_mode,
                                        s_q.sec[1], s_q.sec_o};
         hbp_pkg::OFS_LATCH:  rd_mux = s_q.latch;
         default:             rd_mux = hbp_pkg::UNMAPPED_VAL;
      endcase
   end

   // ****************************************************
   // Next state
   // ****************************************************
   // Address and data pass the same two stages as the strobes, so a
   // write edge sees the address that stood with it; the host must keep
   // them steady for a few reference clocks around each strobe edge.
   always_comb
   begin
      s_d         = s_q;
      s_d.rst_n   = {s_q.rst_n[1:0], HOST_RESET_N};
      s_d.bclk    = {s_q.bclk[1:0], HOST_BUS_CLK};
      s_d.refc    = {s_q.refc[1:0], FRAME_RATE_REF_IN};
      s_d.sec     = {s_q.sec[1:0], SECOND_PULSE_PIN_I};
      s_d.a2      = {s_q.a2[1:0], CTRL_WNR_RD_N};
      s_d.a1      = {s_q.a1[1:0], CTRL_AS_N_WR_N};
      s_d.cs_n    = {s_q.cs_n[0], HOST_SELECT_N};
      s_d.tsel    = {s_q.tsel[0], BUS_TIMING_SELECT};
      s_d.addr    = {s_q.addr[0], HOST_ADDR};
      s_d.din     = {s_q.din[0], HOST_DATA_I};
      // Writes only land while selected; idle pins change nothing.
      if (do_wr)
      begin
         s_d.mode = s_q.din[1];
      end
      // Divider toggles twice per period of SEC_DIV reference edges.
      if (ref_rise)
      begin
         s_d.ref_cnt = s_q.ref_cnt + 8'h01;
         if (s_q.div == DIV_LAST)
         begin
            s_d.div   = 13'h0000;
            s_d.sec_o = 1'b0;
         end
         else
         begin
            s_d.div = s_q.div + 13'h0001;
            if (s_q.div == DIV_HALF)
            begin
               s_d.sec_o = 1'b1;
            end
         end
      end
      // Snapshot of the reference count on an external second.
      if (!sec_out && sec_rise)
      begin
         s_d.latch = s_q.ref_cnt;
      end
      // Read data is re-registered every cycle, so it follows the address
      // live; the bus only sees it while a qualified read holds OE high.
      s_d.rdata = rd_mux;
      s_d.oe    = sync_rd || async_rd;
      // Device reset clears control and restarts the divider.
      if (dev_rst)
      begin
         s_d.mode    = hbp_pkg::MODE_RST;
         s_d.div     = 13'h0000;
         s_d.sec_o   = 1'b0;
         s_d.ref_cnt = 8'h00;
         s_d.latch   = 8'h00;
         s_d.oe      = 1'b0;
      end
   end

   // ****************************************************
   // Registers
   // ****************************************************
   // Reset parks select and strobe synchronisers at their idle levels and the reset synchroniser low.
   always_ff @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         s_q       <= '0;
         s_q.rst_n <= 3'h0;
         s_q.cs_n  <= 2'h3;
         s_q.a1    <= 3'h7;
         s_q.a2    <= 3'h7;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from flip-flops, save HOST_IRQ_N, tied high; no interrupt source exists.
   assign HOST_DATA_O         = s_q.rdata;
   assign HOST_DATA_OE        = s_q.oe;
   assign HOST_IRQ_N          = 1'b1;
   assign SECOND_PULSE_PIN_O  = s_q.sec_o;
   assign SECOND_PULSE_PIN_OE = s_q.mode[0];

   // ****************************************************
   // Checks
   // ****************************************************
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);
   // Most checks wait out device reset in their antecedent, so the two
   // edges in which the reset synchroniser still reads low after a system
   // reset cannot raise a false failure. The interrupt check is fixed by
   // construction, since the port has no interrupt source of its own.

   property p_dev_reset;
      dev_rst |=> s_q.mode == 8'h00 && !HOST_DATA_OE;
   endproperty
   a_dev_reset: assert property (p_dev_reset)
      else $error("Mode not cleared in device reset.");

   property p_div_restart;
      dev_rst |=> s_q.div == 13'h0000;
   endproperty
   a_div_restart: assert property (p_div_restart)
      else $error("Divider not restarted by reset.");

   property p_sec_high;
      ref_rise && !dev_rst && s_q.div == DIV_HALF |=> s_q.sec_o;
   endproperty
   a_sec_high: assert property (p_sec_high)
      else $error("Second output missed its rising point.");

   property p_sec_low;
      ref_rise && !dev_rst && s_q.div == DIV_LAST
         |=> !s_q.sec_o && s_q.div == 13'h0000;
   endproperty
   a_sec_low: assert property (p_sec_low)
      else $error("Second output missed its wrap.");

   property p_latch;
      !sec_out && sec_rise && !dev_rst
         |=> s_q.latch == $past(s_q.ref_cnt);
   endproperty
   a_latch: assert property (p_latch)
      else $error("Latch did not capture the count.");

   property p_pin_dir;
      do_wr |=> SECOND_PULSE_PIN_OE
         == $past(s_q.din[1][hbp_pkg::MODE_SEC_OUT_BIT]);
   endproperty
   a_pin_dir: assert property (p_pin_dir)
      else $error("Pin direction does not follow mode bit.");

   property p_sync_wr;
      sync_wr && s_q.addr[1] == hbp_pkg::OFS_MODE
         |=> s_q.mode == $past(s_q.din[1]);
   endproperty
   a_sync_wr: assert property (p_sync_wr)
      else $error("Strobe mode write lost.");

   property p_sync_rd;
      sync_rd ##1 sync_rd |=> HOST_DATA_OE
         && HOST_DATA_O == $past(rd_mux);
   endproperty
   a_sync_rd: assert property (p_sync_rd)
      else $error("Strobe mode read not driven.");

   property p_async_rd;
      async_rd |=> HOST_DATA_OE ##0 HOST_DATA_O == $past(rd_mux);
   endproperty
   a_async_rd: assert property (p_async_rd)
      else $error("Async read not driven.");

   property p_async_wr;
      async_wr && s_q.addr[1] == hbp_pkg::OFS_MODE
         |=> s_q.mode == $past(s_q.din[1]);
   endproperty
   a_async_wr: assert property (p_async_wr)
      else $error("Async write lost.");

   property p_async_block;
      !strobe_mode && wr_fall && !s_q.a2[1] && !dev_rst
         |=> $stable(s_q.mode);
   endproperty
   a_async_block: assert property (p_async_block)
      else $error("Write taken during a read.");

   property p_deselect;
      !cs_on && !dev_rst |=> !HOST_DATA_OE && $stable(s_q.mode);
   endproperty
   a_deselect: assert property (p_deselect)
      else $error("Deselected port reacted.");

   property p_irq;
      HOST_IRQ_N [*2];
   endproperty
   a_irq: assert property (p_irq)
      else $error("Interrupt output not held inactive.");

   c_sync_wr: cover property (sync_wr && do_wr);
   c_async_rd: cover property (async_rd ##1 HOST_DATA_OE);
   c_sec_wrap: cover property (ref_rise && s_q.div == DIV_LAST);
   c_latch: cover property (!sec_out && sec_rise);

endmodule
`default_nettype wire

// ### testbench/hbp_host_model.sv
// Host side timing model: host bus clock and frame-rate reference.
`default_nettype none
module hbp_host_model
(
   output logic bus_clk,
   output logic frame_ref
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // Clocks
   // ****************
   // The bus clock runs from time zero, well before reset release.
   initial
   begin
      bus_clk = 1'b0;
      forever #150 bus_clk = ~bus_clk;
   end
   // Reference period is 500 ns, scaled from 8 kHz to keep runs short.
   initial
   begin
      frame_ref = 1'b0;
      forever #250 frame_ref = ~frame_ref;
   end
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the host bus port.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 8;
   logic        ref_clk   = 1'b0;
   logic        sys_rst   = 1'b1;
   logic        rst_n     = 1'b1;
   logic        strobe_md = 1'b1;
   logic        sel_n     = 1'b1;
   logic        ctl_a     = 1'b0;
   logic        ctl_b     = 1'b1;
   logic [10:0] addr      = 11'h000;
   logic [7:0]  wdata     = 8'h00;
   logic        take      = 1'b0;
   logic        pin_drv   = 1'b0;
   int          ref_seen  = 0;
   int          ref_base  = 0;
   logic        bus_clk, frame_ref, pin_o, pin_oe, irq_n, oe, pin_w;
   logic [7:0]  dout, dwire, mval;
   logic [8:0]  expq[$];
   int          bad_count  = 0;
   int          n_compared = 0;
   int          seed       = 32;
   int          cycles     = 0;
   realtime     t0;
   // The data wire resolves the device driver against the host's data.
   assign dwire = oe ? dout : wdata;
   assign pin_w = pin_oe ? pin_o : pin_drv;
   // Reference rises as the host sees them; the latch test counts these.
   always @(posedge frame_ref)
      ref_seen++;
   hbp_host_model u_hbp_host_model (.bus_clk(bus_clk),
      .frame_ref(frame_ref));
   hbp_top #(.SEC_DIV(DIV)) u_hbp_top (.REF_CLK(ref_clk),
      .SYS_RST(sys_rst), .HOST_RESET_N(rst_n), .HOST_BUS_CLK(bus_clk),
      .BUS_TIMING_SELECT(strobe_md), .HOST_SELECT_N(sel_n),
      .CTRL_WNR_RD_N(ctl_a), .CTRL_AS_N_WR_N(ctl_b), .HOST_ADDR(addr),
      .HOST_DATA_I(dwire), .HOST_DATA_O(dout), .HOST_DATA_OE(oe),
      .HOST_IRQ_N(irq_n), .FRAME_RATE_REF_IN(frame_ref),
      .SECOND_PULSE_PIN_I(pin_w), .SECOND_PULSE_PIN_O(pin_o),
      .SECOND_PULSE_PIN_OE(pin_oe));
   // ****************
   // Clock and checks
   // ****************
   initial
   begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic check(input string nm, input logic [8:0] seen,
                        input logic [8:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      if (bad_count == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // A hang shows as a stuck wait; the ceiling is well above a clean run.
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         bad_count++;
         finish_test();
      end
   end
   // The monitor takes the oldest note whenever a read result is due.
   always @(posedge ref_clk)
      if (take)
         check("read", {oe, dout & {8{oe}}},
               expq.pop_front());
   // ****************
   // Bus tasks
   // ****************
   // Write in either mode; 30 cycles span at least two bus clock rises.
   task automatic wr(input logic [10:0] a, input logic [7:0] d,
                     input logic cs_n, input logic rd_n);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      sel_n <= cs_n;
      ctl_a <= strobe_md | rd_n;
      ctl_b <= ~strobe_md;
      tick(6);
      ctl_b <= 1'b0;
      tick(30);
      ctl_b <= 1'b1;
      tick(6);
      sel_n <= 1'b1;
      ctl_a <= ~strobe_md;
      tick(6);
   endtask
   // Read in either mode; the result is noted before the strobe is set.
   task automatic rd(input logic [10:0] a, input logic cs_n,
                     input logic [8:0] exp);
      @(posedge ref_clk);
      addr  <= a;
      sel_n <= cs_n;
      ctl_a <= 1'b0;
      ctl_b <= ~strobe_md;
      expq.push_back(exp);
      tick(6);
      take <= 1'b1;
      tick(1);
      take  <= 1'b0;
      sel_n <= 1'b1;
      ctl_a <= ~strobe_md;
      ctl_b <= 1'b1;
      tick(6);
   endtask
   // ****************
   // Main sequence
   // ****************
   initial
   begin
      tick(5);
      sys_rst <= 1'b0;
      tick(6);
      check("irq", {8'h00, irq_n}, 9'h001);
      rd(11'h200, 1'b0, 9'h100);
      mval = 8'($random(seed)) | 8'h01;
      wr(11'h200, mval, 1'b0, 1'b1);
      rd(11'h200, 1'b0, {1'b1, mval});
      check("pin_oe", {8'h00, pin_oe}, 9'h001);
      wr(11'h200, ~mval, 1'b1, 1'b1);
      rd(11'h200, 1'b1, 9'h000);
      wr(11'h600, ~mval, 1'b0, 1'b1);
      rd(11'h200, 1'b0, {1'b1, mval});
      rd(11'h7ff, 1'b0, 9'h100);
      // Each pin period spans DIV reference periods of 500 ns.
      @(posedge pin_o);
      t0 = $realtime;
      @(posedge pin_o);
      check("period", 9'(int'(($realtime - t0) / 500.0)), 9'(DIV));
      // Async mode: a write with the read strobe low must be refused.
      strobe_md <= 1'b0;
      ctl_a     <= 1'b1;
      tick(6);
      wr(11'h200, 8'h5a, 1'b0, 1'b0);
      rd(11'h200, 1'b0, {1'b1, mval});
      wr(11'h200, 8'ha4, 1'b0, 1'b1);
      rd(11'h200, 1'b0, 9'h1a4);
      check("pin_oe", {8'h00, pin_oe}, 9'h000);
      // Device reset clears the mode register and restarts the divider.
      wr(11'h200, mval, 1'b0, 1'b1);
      rst_n <= 1'b0;
      tick(10);
      rst_n    <= 1'b1;
      ref_base  = ref_seen;
      tick(8);
      check("pin_o", {pin_oe, pin_o, 7'h00}, 9'h000);
      rd(11'h200, 1'b0, 9'h100);
      // A pin rise in input mode snapshots the reference count since reset.
      pin_drv <= 1'b1;
      mval     = 8'(ref_seen - ref_base);
      tick(6);
      rd(11'h202, 1'b0, {1'b1, mval});
      rd(11'h201, 1'b0, 9'h102);
      finish_test();
   end
endmodule
`default_nettype wire
